/* logic/qdr_readback.sv */
// Overview of operation
// - Acknowledge matching write address by pulling data low
// - Address is 10011, two strap bits, direction
// - Accept and acknowledge the following control byte
// - Acknowledge read address, then transmit read-back bytes
// - Flag clear: send high byte, then low
// - Flag set: power-down, high, then low byte
// - Channel chosen by control bits two and one
// - High byte carries code bits 11..4, MSB first
// - Low byte: code bits 3..0, then filler
// - Power-down byte: two mode bits, six ones
// - Control byte LSB is the power-down flag
`timescale 1ns/10ps
`default_nettype none
`include "qdr_defines.svh"

module qdr_readback
    import qdr_pkg::*;
#(
    parameter int CODE_W = `QDR_CODE_W,
    parameter int NUM_CH = `QDR_NUM_CH
) (
    input  wire logic                     CLOCK,
    input  wire logic                     RST_B,
    input  wire logic                     CE,
    input  wire logic                     SCL_IN,
    input  wire logic                     SDA_IN,
    output logic                          SDA_OUT,
    output logic                          SDA_OE,
    input  wire logic                     STRAP_ADDR_UPPER,
    input  wire logic                     STRAP_ADDR_LOWER,
    input  wire logic [NUM_CH*CODE_W-1:0] CH_CODE,
    input  wire logic [NUM_CH*2-1:0]      CH_PD_MODE,
    output logic [7:0]                    CTRL_BYTE,
    output logic                          CTRL_STROBE,
    output logic                          BUSY
);

    qdr_regs_t r_q;
    qdr_regs_t r_d;

    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;

    qdr_bus_sense u_sense (
        .clk      (CLOCK),
        .rst_b    (RST_B),
        .ce       (CE),
        .scl      (SCL_IN),
        .sda      (SDA_IN),
        .scl_rise (scl_rise),
        .scl_fall (scl_fall),
        .start    (start),
        .stop     (stop)
    );

    // Position in the read-back sequence for a byte index
    function automatic logic [1:0] seq_of(input logic [7:0] ctrl,
                                          input logic [1:0] idx);
        if (ctrl[`QDR_PD_FLAG_BIT]) begin
            seq_of = idx;
        end else begin
            seq_of = 2'(idx + 2'h1);
        end
    endfunction

    // Byte to transmit for a given index
    function automatic logic [7:0] tx_byte(input logic [7:0] ctrl,
                                           input logic [1:0] idx);
        logic [1:0]        sel;
        logic [CODE_W-1:0] code;
        logic [1:0]        pd;
        sel  = {ctrl[`QDR_SEL_HI_BIT], ctrl[`QDR_SEL_LO_BIT]};
        code = CH_CODE[int'(sel)*CODE_W +: CODE_W];
        pd   = CH_PD_MODE[int'(sel)*2 +: 2];
        case (seq_of(ctrl, idx))
            `QDR_SEQ_PD:   tx_byte = {pd, `QDR_PD_FILL};
            `QDR_SEQ_HIGH: tx_byte = code[CODE_W-1 -: 8];
            default:       tx_byte = {code[3:0], `QDR_LOW_FILL};
        endcase
    endfunction

    logic       addr_match;
    logic       last_byte;
    logic [6:0] own_addr;
    logic [7:0] first_byte;
    logic [7:0] next_byte;

    // Own address and the bytes waiting to be sent
    always_comb begin
        own_addr   = {`QDR_ADDR_FIXED,
                      STRAP_ADDR_UPPER, STRAP_ADDR_LOWER};
        addr_match = (r_q.shift[7:1] == own_addr);
        last_byte  = (seq_of(r_q.ctrl, r_q.idx) == `QDR_SEQ_LOW);
        first_byte = tx_byte(r_q.ctrl, 2'h0);
        next_byte  = tx_byte(r_q.ctrl, 2'(r_q.idx + 2'h1));
    end

    always_comb begin
        r_d            = r_q;
        r_d.ctrl_pulse = 1'b0;
        r_d.sda_out    = 1'b0;
        if (start) begin
            // Start or repeated start: address phase follows
            r_d.st  = QDR_ADDR;
            r_d.cnt = 4'h0;
            r_d.oe  = 1'b0;
        end else if (stop) begin
            r_d.st = QDR_IDLE;
            r_d.oe = 1'b0;
        end else begin
            case (r_q.st)
                QDR_ADDR, QDR_CTRL: begin
                    if (scl_rise && r_q.cnt != `QDR_BITS_BYTE) begin
                        r_d.shift = {r_q.shift[6:0], SDA_IN};
                        r_d.cnt   = 4'(r_q.cnt + 4'h1);
                    end else if (scl_fall && r_q.cnt == `QDR_BITS_BYTE) begin
                        if (r_q.st == QDR_CTRL) begin
                            r_d.ctrl       = r_q.shift;
                            r_d.ctrl_pulse = 1'b1;
                            r_d.oe         = 1'b1;
                            r_d.st         = QDR_CTRL_ACK;
                        end else if (addr_match) begin
                            r_d.rw = r_q.shift[0];
                            r_d.oe = 1'b1;
                            r_d.st = QDR_ADDR_ACK;
                        end else begin
                            r_d.st = QDR_WAIT;
                        end
                    end
                end
                QDR_ADDR_ACK: begin
                    if (scl_fall) begin
                        r_d.cnt = 4'h0;
                        if (r_q.rw) begin
                            // Turn around into transmitter
                            r_d.idx   = 2'h0;
                            r_d.shift = {first_byte[6:0], 1'b0};
                            r_d.oe    = ~first_byte[7];
                            r_d.cnt   = 4'h1;
                            r_d.st    = QDR_TX;
                        end else begin
                            r_d.oe = 1'b0;
                            r_d.st = QDR_CTRL;
                        end
                    end
                end
                QDR_CTRL_ACK: begin
                    if (scl_fall) begin
                        r_d.oe = 1'b0;
                        r_d.st = QDR_WAIT;
                    end
                end
                QDR_TX: begin
                    if (scl_fall) begin
                        if (r_q.cnt == `QDR_BITS_BYTE) begin
                            r_d.oe = 1'b0;
                            r_d.st = QDR_TX_ACK;
                        end else begin
                            r_d.oe    = ~r_q.shift[7];
                            r_d.shift = {r_q.shift[6:0], 1'b0};
                            r_d.cnt   = 4'(r_q.cnt + 4'h1);
                        end
                    end
                end
                QDR_TX_ACK: begin
                    if (scl_rise) begin
                        r_d.mack = ~SDA_IN;
                    end else if (scl_fall) begin
                        if (!r_q.mack) begin
                            r_d.oe = 1'b0;
                            r_d.st = QDR_IDLE;
                        end else if (last_byte) begin
                            r_d.oe = 1'b0;
                            r_d.st = QDR_WAIT;
                        end else begin
                            r_d.idx   = 2'(r_q.idx + 2'h1);
                            r_d.shift = {next_byte[6:0], 1'b0};
                            r_d.oe    = ~next_byte[7];
                            r_d.cnt   = 4'h1;
                            r_d.st    = QDR_TX;
                        end
                    end
                end
                QDR_IDLE, QDR_WAIT: begin
                    r_d.oe = 1'b0;
                end
                default: begin
                    r_d.oe = 1'b0;
                    r_d.st = QDR_IDLE;
                end
            endcase
        end
        r_d.busy = (r_d.st != QDR_IDLE);
    end

    // State register, frozen while CE is low
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            r_q <= '{st: QDR_IDLE, ctrl: `QDR_CTRL_RESET, default: '0};
        end else if (CE) begin
            r_q <= r_d;
        end
    end

    // Outputs straight from the state register
    assign SDA_OUT     = r_q.sda_out;
    assign SDA_OE      = r_q.oe;
    assign CTRL_BYTE   = r_q.ctrl;
    assign CTRL_STROBE = r_q.ctrl_pulse;
    assign BUSY        = r_q.busy;

endmodule

`default_nettype wire

/* logic/qdr_defines.svh */
`ifndef QDR_DEFINES_SVH
`define QDR_DEFINES_SVH

// Address byte layout
`define QDR_ADDR_FIXED   5'h13
// Control byte field positions
`define QDR_PD_FLAG_BIT  0
`define QDR_SEL_HI_BIT   2
`define QDR_SEL_LO_BIT   1
`define QDR_CTRL_RESET   8'h00
// Read-back byte fill values
`define QDR_PD_FILL      6'h3F
`define QDR_LOW_FILL     4'h0
// Sizes and counts
`define QDR_CODE_W       12
`define QDR_NUM_CH       4
`define QDR_BITS_BYTE    4'h8
`define QDR_SEQ_PD       2'h0
`define QDR_SEQ_HIGH     2'h1
`define QDR_SEQ_LOW      2'h2

`endif

/* logic/qdr_pkg.sv */
package qdr_pkg;

    typedef enum logic [7:0] {
        QDR_IDLE     = 8'h01,
        QDR_ADDR     = 8'h02,
        QDR_ADDR_ACK = 8'h04,
        QDR_CTRL     = 8'h08,
        QDR_CTRL_ACK = 8'h10,
        QDR_TX       = 8'h20,
        QDR_TX_ACK   = 8'h40,
        QDR_WAIT     = 8'h80
    } qdr_state_t;

    typedef struct packed {
        logic scl_prev;
        logic sda_prev;
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
    } qdr_sense_t;

    typedef struct packed {
        qdr_state_t st;
        logic [7:0] shift;
        logic [3:0] cnt;
        logic       rw;
        logic [7:0] ctrl;
        logic [1:0] idx;
        logic       mack;
        logic       oe;
        logic       sda_out;
        logic       busy;
        logic       ctrl_pulse;
    } qdr_regs_t;

endpackage

/* logic/qdr_bus_sense.sv */
`timescale 1ns/10ps
`default_nettype none

module qdr_bus_sense
    import qdr_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic ce,
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_rise,
    output logic      scl_fall,
    output logic      start,
    output logic      stop
);

    qdr_sense_t s_q;
    qdr_sense_t s_d;

    // Edge and bus condition detection
    always_comb begin
        s_d          = s_q;
        s_d.scl_prev = scl;
        s_d.sda_prev = sda;
        s_d.scl_rise = scl & ~s_q.scl_prev;
        s_d.scl_fall = ~scl & s_q.scl_prev;
        s_d.start    = scl & s_q.scl_prev & s_q.sda_prev & ~sda;
        s_d.stop     = scl & s_q.scl_prev & ~s_q.sda_prev & sda;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '{scl_prev: 1'b1, sda_prev: 1'b1, default: 1'b0};
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign scl_rise = s_q.scl_rise;
    assign scl_fall = s_q.scl_fall;
    assign start    = s_q.start;
    assign stop     = s_q.stop;

endmodule

`default_nettype wire

/* testbench/qdr_readback_monitor.sv */
`timescale 1ns/10ps
`default_nettype none

module qdr_readback_monitor (
    input  wire logic       CLOCK,
    input  wire logic       RST_B,
    input  wire logic       CE,
    input  wire logic       SCL_IN,
    input  wire logic       SDA_IN,
    input  wire logic       SDA_OUT,
    input  wire logic       SDA_OE,
    input  wire logic [7:0] CTRL_BYTE,
    input  wire logic       CTRL_STROBE,
    input  wire logic       BUSY
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_B);

    chk_out_low: assert property (SDA_OUT == 1'h0)
        else $error("data output not low");
    chk_rise_scl_low: assert property ($rose(SDA_OE) |-> !SCL_IN)
        else $error("drive began with bus clock high");
    chk_oe_stands: assert property ($rose(SDA_OE) |=> SDA_OE [*8])
        else $error("drive too short");
    chk_strobe_one: assert property (CTRL_STROBE |=> !CTRL_STROBE)
        else $error("strobe longer than one cycle");
    chk_strobe_ack: assert property (CTRL_STROBE |-> ##[0:1] SDA_OE)
        else $error("control byte not acknowledged");
    chk_ctrl_cause: assert property ($changed(CTRL_BYTE) |->
        CTRL_STROBE || $past(CTRL_STROBE))
        else $error("control byte changed without strobe");
    chk_idle_quiet: assert property (!BUSY |-> !SDA_OE)
        else $error("driving while idle");
    chk_addr_quiet: assert property ($rose(BUSY) |-> !SDA_OE [*8])
        else $error("driving during address");
    chk_start_busy: assert property (CE && SCL_IN && $past(SCL_IN) &&
        $fell(SDA_IN) |-> ##[1:4] BUSY)
        else $error("start not seen");
    chk_stop_idle: assert property (SCL_IN && $past(SCL_IN) &&
        $rose(SDA_IN) |-> ##[1:4] (!BUSY && !SDA_OE))
        else $error("stop not seen");
endmodule

bind qdr_readback qdr_readback_monitor mon_u (
    .CLOCK(CLOCK), .RST_B(RST_B), .CE(CE), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
    .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .CTRL_BYTE(CTRL_BYTE),
    .CTRL_STROBE(CTRL_STROBE), .BUSY(BUSY)
);

`default_nettype wire

/* testbench/qdr_bus_master.sv */
`timescale 1ns/10ps
`default_nettype none

module qdr_bus_master (
    input  wire logic       clk,
    input  wire logic       sda_w,
    output logic            scl,
    output logic            sda_m,
    output logic [7:0]      res,
    output logic            res_v
);
    logic r;

    initial begin
        scl = 1'h1;
        sda_m = 1'h1;
        res = 8'h00;
        res_v = 1'h0;
    end

    task automatic hp(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Data moves only while the bus clock is low
    task automatic clk_bit(input logic b);
        sda_m <= b;
        hp(5);
        scl <= 1'h1;
        hp(5);
        r = sda_w;
        scl <= 1'h0;
        hp(2);
    endtask

    task automatic start();
        sda_m <= 1'h1;
        hp(5);
        scl <= 1'h1;
        hp(5);
        sda_m <= 1'h0;
        hp(5);
        scl <= 1'h0;
        hp(2);
    endtask

    task automatic stop();
        sda_m <= 1'h0;
        hp(5);
        scl <= 1'h1;
        hp(5);
        sda_m <= 1'h1;
        hp(5);
    endtask

    task automatic put(input logic [7:0] v);
        res <= v;
        res_v <= 1'h1;
        @(posedge clk);
        res_v <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) clk_bit(v[i]);
        clk_bit(1'h1);
        put({7'h00, r});
    endtask

    // Acknowledge all but the last byte
    task automatic rd(input logic last);
        logic [7:0] v;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'h1);
            v[i] = r;
        end
        clk_bit(last);
        put(v);
    endtask
endmodule

`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    logic        clock, rst_b, ce, up, lo, oe, so, cs, busy;
    logic        scl, sdam, rv, sda_w, pd;
    logic [47:0] codes;
    logic [11:0] code;
    logic [7:0]  pdm, cb, res, ad;
    logic [7:0]  exp_q [$];
    int          n_fail, checks, cyc, ch;

    assign sda_w = sdam & (~oe | so);

    qdr_readback dut_u (
        .CLOCK(clock), .RST_B(rst_b), .CE(ce), .SCL_IN(scl),
        .SDA_IN(sda_w), .SDA_OUT(so), .SDA_OE(oe),
        .STRAP_ADDR_UPPER(up), .STRAP_ADDR_LOWER(lo), .CH_CODE(codes),
        .CH_PD_MODE(pdm), .CTRL_BYTE(cb), .CTRL_STROBE(cs), .BUSY(busy)
    );
    qdr_bus_master mst_u (
        .clk(clock), .sda_w(sda_w), .scl(scl), .sda_m(sdam),
        .res(res), .res_v(rv)
    );

    task automatic check(input string nm, input logic [7:0] seen,
                         input logic [7:0] want);
        checks++;
        if (seen !== want) begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", nm, want, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        clock = 1'h0;
        forever #5 clock = ~clock;
    end

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (rv) begin
            check("bus byte", res, exp_q.pop_front());
        end
        if (cyc == 20000) begin
            n_fail++;
            give_verdict();
        end
    end

    initial begin
        rst_b = 1'h0;
        ce = 1'h1;
        void'($urandom(60));
        {up, lo, codes, pdm} = 58'({$urandom, $urandom});
        repeat (6) @(posedge clock);
        rst_b <= 1'h1;
        repeat (2) @(posedge clock);
        for (int k = 0; k < 8; k++) begin
            ch = k % 4;
            pd = k[2];
            up <= 1'($urandom);
            lo <= 1'($urandom);
            codes <= {16'($urandom), 32'($urandom)};
            pdm <= 8'($urandom);
            @(posedge clock);
            code = codes[ch*12 +: 12];
            ad = {5'h13, up, lo, 1'h0};
            mst_u.start();
            exp_q.push_back(8'h00);
            mst_u.wr(ad);
            exp_q.push_back(8'h00);
            mst_u.wr({5'h00, ch[1:0], pd});
            check("ctrl", cb, {5'h00, ch[1:0], pd});
            mst_u.start();
            exp_q.push_back(8'h00);
            mst_u.wr(ad | 8'h01);
            if (pd) begin
                exp_q.push_back({pdm[ch*2 +: 2], 6'h3F});
                mst_u.rd(1'h0);
            end
            exp_q.push_back(code[11:4]);
            mst_u.rd(1'h0);
            exp_q.push_back({code[3:0], 4'h0});
            mst_u.rd(1'h1);
            repeat (4) @(posedge clock);
            check("idle", {6'h00, busy, oe}, 8'h00);
            if (k[0]) mst_u.stop();
        end
        ce <= 1'h0;
        mst_u.start();
        check("frozen", {6'h00, busy, oe}, 8'h00);
        ce <= 1'h1;
        mst_u.stop();
        mst_u.start();
        exp_q.push_back(8'h01);
        mst_u.wr({5'h13, ~up, lo, 1'h0});
        mst_u.stop();
        repeat (4) @(posedge clock);
        check("busy", {7'h00, busy}, 8'h00);
        give_verdict();
    end
endmodule

`default_nettype wire
